// file: include/tsec_defines.svh
// register offsets, field positions and reset values for the stamp and epoch block
// assumes an external i2c slave turns bus cycles into byte register accesses
`ifndef TSEC_DEFINES_SVH
`define TSEC_DEFINES_SVH
`define TSEC_ADDR_MONTH_STAMP 8'h19
`define TSEC_ADDR_YEAR_STAMP 8'h1a
`define TSEC_ADDR_EPOCH0 8'h1b
`define TSEC_ADDR_EPOCH1 8'h1c
`define TSEC_ADDR_EPOCH2 8'h1d
`define TSEC_ADDR_EPOCH3 8'h1e
`define TSEC_MONTH_MSB 4
`define TSEC_STAMP_RESET 8'h00
`define TSEC_MONTH_RESET 5'h00
`define TSEC_EPOCH_RESET 32'h0000_0000
`define TSEC_EPOCH_ONE 32'h0000_0001
`define TSEC_READ_IDLE 8'h00
`endif

// file: include/tsec_pkg.sv
// types shared by the stamp and epoch block
// assumes tsec_defines.svh is available to the design files
package tsec_pkg;
   // one byte access from the i2c slave
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } tsec_bus_req_t;
   // calendar values offered by the time keeper at a stamp event
   typedef struct packed {
      logic [4:0] month;
      logic [7:0] year;
   } tsec_cal_t;
endpackage : tsec_pkg

// file: src/tsec_top.sv
// stamp month/year capture and 32-bit binary epoch seconds counter with byte registers
// assumes bus requests, tick and stamp events are synchronous single-cycle pulses
//
// Contract
// - month stamp holds BCD month in bits 4:0, 01 to 12 once captured
// - month stamp bits 7:5 always read zero, writes ignored
// - stamp clear written one clears month stamp to 00h
// - after reset or clear month is 00 until next capture gives a month
// - year stamp holds two BCD digits in all eight bits, 00 to 99
// - both stamp registers read-only; writes leave them unchanged
// - stamps capture only while stamp enable is one
// - overwrite select chooses first event kept or latest event shown
// - stamp clear written one also clears year stamp to 00h
// - a 32-bit epoch seconds counter kept in plain binary
// - epoch counter wraps from all ones to zero
// - epoch counter increments once per tuned 1 Hz tick
// - four epoch byte registers readable and writable, writes load counter
// - increments suppressed while a bus write to epoch registers runs
// - epoch registers always readable, writes blocked while write_protect_i is one
// - lowest epoch byte register shows counter bits 7:0
// - second epoch byte register shows counter bits 15:8
// - third and fourth bytes show bits 23:16 and 31:24 at next addresses
// - month stamp sits just before year stamp and resets to zero
`timescale 1ns/1ps
`include "tsec_defines.svh"

module tsec_top #(
   parameter int EPOCH_W = 32
) (
   // clock, reset, enable
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   // byte register access from the i2c slave
   input wire tsec_pkg::tsec_bus_req_t bus_req_i,
   input wire logic bus_wr_txn_i,
   input wire logic bus_rd_start_i,
   output logic [7:0] bus_rdata_o,
   output logic bus_rvalid_o,
   // stamp control and event
   input wire logic stamp_enable_i,
   input wire logic stamp_overwrite_select_i,
   input wire logic stamp_clear_i,
   input wire logic stamp_event_i,
   input wire tsec_pkg::tsec_cal_t stamp_cal_i,
   // tick and protection
   input wire logic tick_1hz_i,
   input wire logic write_protect_i,
   // state views
   output logic [EPOCH_W-1:0] epoch_count_o,
   output logic stamp_valid_o
);

   //==========================================================
   // helpers
   function automatic logic is_epoch_addr(input logic [7:0] a);
      is_epoch_addr = (a >= `TSEC_ADDR_EPOCH0) && (a <= `TSEC_ADDR_EPOCH3);
   endfunction : is_epoch_addr

   function automatic logic [1:0] epoch_lane(input logic [7:0] a);
      logic [7:0] d;
      d = a - `TSEC_ADDR_EPOCH0;
      epoch_lane = d[1:0];
   endfunction : epoch_lane

   //==========================================================
   // stamp registers
   logic [4:0] month_stamp_r;
   logic [7:0] year_stamp_r;
   logic stamp_valid_r;
   logic stamp_take;

   // first-event mode keeps the stamp once taken; latest mode always updates
   assign stamp_take = stamp_event_i && stamp_enable_i
      && (stamp_overwrite_select_i || !stamp_valid_r);

   // a capture wins over a clear in the same cycle
   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
         month_stamp_r <= `TSEC_MONTH_RESET;
      else if (ce_i)
      begin
         if (stamp_take)
            month_stamp_r <= stamp_cal_i.month;
         else if (stamp_clear_i)
            month_stamp_r <= `TSEC_MONTH_RESET;
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
         year_stamp_r <= `TSEC_STAMP_RESET;
      else if (ce_i)
      begin
         if (stamp_take)
            year_stamp_r <= stamp_cal_i.year;
         else if (stamp_clear_i)
            year_stamp_r <= `TSEC_STAMP_RESET;
      end
   end

   // the valid flag is what lets first-event mode refuse later captures
   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
         stamp_valid_r <= 1'b0;
      else if (ce_i)
      begin
         if (stamp_take)
            stamp_valid_r <= 1'b1;
         else if (stamp_clear_i)
            stamp_valid_r <= 1'b0;
      end
   end

   //==========================================================
   // epoch counter
   logic [EPOCH_W-1:0] epoch_r;
   logic [EPOCH_W-1:0] epoch_nxt;
   logic ep_wr;
   logic [1:0] lane;

   assign ep_wr = bus_req_i.wr && is_epoch_addr(bus_req_i.addr) && !write_protect_i;
   assign lane = epoch_lane(bus_req_i.addr);

   always_comb
   begin
      epoch_nxt = epoch_r;
      // tick held off for the whole write transaction
      if (tick_1hz_i && !bus_wr_txn_i && !bus_req_i.wr)
         epoch_nxt = epoch_r + EPOCH_W'(`TSEC_EPOCH_ONE);
      if (ep_wr)
         epoch_nxt[lane*8 +: 8] = bus_req_i.wdata;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
         epoch_r <= EPOCH_W'(`TSEC_EPOCH_RESET);
      else if (ce_i)
         epoch_r <= epoch_nxt;
   end

   //==========================================================
   // read path with snapshot
   logic [EPOCH_W-1:0] snap_r;
   logic [7:0] rdata_r;
   logic rvalid_r;

   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
         snap_r <= EPOCH_W'(`TSEC_EPOCH_RESET);
      else if (ce_i && bus_rd_start_i)
         snap_r <= epoch_r;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
         rdata_r <= `TSEC_READ_IDLE;
      else if (ce_i)
      begin
         if (bus_req_i.rd)
         begin
            if (bus_req_i.addr == `TSEC_ADDR_MONTH_STAMP)
               rdata_r <= {3'h0, month_stamp_r};
            else if (bus_req_i.addr == `TSEC_ADDR_YEAR_STAMP)
               rdata_r <= year_stamp_r;
            else if (bus_req_i.addr == `TSEC_ADDR_EPOCH0)
               rdata_r <= snap_r[7:0];
            else if (bus_req_i.addr == `TSEC_ADDR_EPOCH1)
               rdata_r <= snap_r[15:8];
            else if (bus_req_i.addr == `TSEC_ADDR_EPOCH2)
               rdata_r <= snap_r[23:16];
            else if (bus_req_i.addr == `TSEC_ADDR_EPOCH3)
               rdata_r <= snap_r[31:24];
            else
               rdata_r <= `TSEC_READ_IDLE;
         end
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
         rvalid_r <= 1'b0;
      else if (ce_i)
         rvalid_r <= bus_req_i.rd;
   end

   assign bus_rdata_o = rdata_r;
   assign bus_rvalid_o = rvalid_r;
   assign epoch_count_o = epoch_r;
   assign stamp_valid_o = stamp_valid_r;

   //==========================================================
   // checks
   a_month_high_zero: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      ce_i && bus_req_i.rd && bus_req_i.addr == `TSEC_ADDR_MONTH_STAMP
      |=> bus_rdata_o[7:5] == 3'h0)
      else $error("month stamp high bits not zero");
   a_month_capture: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      ce_i && stamp_take
      |=> month_stamp_r == $past(stamp_cal_i.month))
      else $error("month stamp not captured");
   a_stamp_clear_month: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      ce_i && stamp_clear_i && !stamp_event_i
      |=> month_stamp_r == `TSEC_MONTH_RESET)
      else $error("month stamp not cleared");
   a_stamp_clear_year: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      ce_i && stamp_clear_i && !stamp_event_i
      |=> year_stamp_r == `TSEC_STAMP_RESET)
      else $error("year stamp not cleared");
   a_valid_clear: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      ce_i && stamp_clear_i && !stamp_take
      |=> !stamp_valid_r)
      else $error("stamp valid not cleared");
   a_month_first_take: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      ce_i && stamp_take && !stamp_valid_r
      |=> stamp_valid_r && month_stamp_r == $past(stamp_cal_i.month))
      else $error("first stamp not taken");

   a_stamp_write_ignored: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      ce_i && bus_req_i.wr && !stamp_event_i && !stamp_clear_i
      |=> $stable(year_stamp_r) && $stable(month_stamp_r))
      else $error("stamp changed by write");
   a_year_read: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      ce_i && bus_req_i.rd && bus_req_i.addr == `TSEC_ADDR_YEAR_STAMP
      |=> bus_rdata_o == $past(year_stamp_r))
      else $error("year stamp read wrong");
   a_stamp_disabled: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      ce_i && !stamp_enable_i && !stamp_clear_i
      |=> $stable(year_stamp_r))
      else $error("stamp captured while disabled");
   a_month_disabled: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      ce_i && !stamp_enable_i && !stamp_clear_i
      |=> $stable(month_stamp_r))
      else $error("month captured while disabled");
   a_stamp_first_kept: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      ce_i && stamp_valid_r && !stamp_overwrite_select_i && !stamp_clear_i
      |=> $stable(month_stamp_r))
      else $error("first stamp overwritten");
   a_year_first_kept: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      ce_i && stamp_valid_r && !stamp_overwrite_select_i && !stamp_clear_i
      |=> $stable(year_stamp_r))
      else $error("first year stamp overwritten");
   a_stamp_latest: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      ce_i && stamp_event_i && stamp_enable_i && stamp_overwrite_select_i
      |=> year_stamp_r == $past(stamp_cal_i.year))
      else $error("latest stamp not taken");

   a_epoch_tick: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      ce_i && tick_1hz_i && !bus_wr_txn_i && !bus_req_i.wr
      |=> epoch_r == $past(epoch_r) + EPOCH_W'(`TSEC_EPOCH_ONE))
      else $error("epoch did not advance");
   a_epoch_idle: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      ce_i && !tick_1hz_i && !ep_wr
      |=> $stable(epoch_r))
      else $error("epoch moved without tick");
   a_epoch_wrap: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      ce_i && tick_1hz_i && !bus_wr_txn_i && !bus_req_i.wr && (&epoch_r)
      |=> epoch_r == EPOCH_W'(`TSEC_EPOCH_RESET))
      else $error("epoch did not wrap");
   a_epoch_hold: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      ce_i && bus_wr_txn_i && !bus_req_i.wr
      |=> $stable(epoch_r))
      else $error("epoch moved during write");
   a_epoch_protect: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      ce_i && bus_req_i.wr && write_protect_i
      |=> $stable(epoch_r))
      else $error("protected epoch written");

   a_epoch_load0: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      ce_i && ep_wr && bus_req_i.addr == `TSEC_ADDR_EPOCH0
      |=> epoch_r[7:0] == $past(bus_req_i.wdata))
      else $error("epoch byte 0 not loaded");
   a_epoch_load1: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      ce_i && ep_wr && bus_req_i.addr == `TSEC_ADDR_EPOCH1
      |=> epoch_r[15:8] == $past(bus_req_i.wdata))
      else $error("epoch byte 1 not loaded");
   a_epoch_load2: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      ce_i && ep_wr && bus_req_i.addr == `TSEC_ADDR_EPOCH2
      |=> epoch_r[23:16] == $past(bus_req_i.wdata))
      else $error("epoch byte 2 not loaded");
   a_epoch_load3: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      ce_i && ep_wr && bus_req_i.addr == `TSEC_ADDR_EPOCH3
      |=> epoch_r[31:24] == $past(bus_req_i.wdata))
      else $error("epoch byte 3 not loaded");

   a_epoch_read0: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      ce_i && bus_req_i.rd && bus_req_i.addr == `TSEC_ADDR_EPOCH0
      |=> bus_rdata_o == $past(snap_r[7:0]))
      else $error("epoch byte 0 read wrong");
   a_epoch_read1: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      ce_i && bus_req_i.rd && bus_req_i.addr == `TSEC_ADDR_EPOCH1
      |=> bus_rdata_o == $past(snap_r[15:8]))
      else $error("epoch byte 1 read wrong");
   a_epoch_read2: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      ce_i && bus_req_i.rd && bus_req_i.addr == `TSEC_ADDR_EPOCH2
      |=> bus_rdata_o == $past(snap_r[23:16]))
      else $error("epoch byte 2 read wrong");
   a_epoch_read3: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      ce_i && bus_req_i.rd && bus_req_i.addr == `TSEC_ADDR_EPOCH3
      |=> bus_rdata_o == $past(snap_r[31:24]))
      else $error("epoch byte 3 read wrong");
   a_snap_take: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      ce_i && bus_rd_start_i
      |=> snap_r == $past(epoch_r))
      else $error("snapshot not taken");
   a_snap_hold: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      ce_i && !bus_rd_start_i
      |=> $stable(snap_r))
      else $error("snapshot moved");
   a_read_answer: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      ce_i && bus_req_i.rd
      |=> bus_rvalid_o)
      else $error("read not answered");
   a_read_quiet: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      ce_i && !bus_req_i.rd
      |=> !bus_rvalid_o)
      else $error("answer without read");
   a_enable_freeze: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      !ce_i
      |=> $stable(epoch_r) && $stable(snap_r) && $stable(year_stamp_r))
      else $error("state moved while disabled");

endmodule : tsec_top

// file: verif/tsec_host_model.sv
// host side model issuing byte register reads and writes
// assumes one bench process calls its tasks
`timescale 1ns/1ps
module tsec_host_model (
   // clock and answer
   input wire logic clk_i,
   input wire logic [7:0] rdata_i,
   input wire logic rvalid_i,
   // requests
   output tsec_pkg::tsec_bus_req_t req_o,
   output logic txn_o,
   output logic rd_start_o
);
   initial
   begin
      req_o = '0;
      txn_o = 1'b0;
      rd_start_o = 1'b0;
   end
   // released address and data show the inverse of their last value
   task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i) req_o <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge clk_i) req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask : op
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
      op(1'b0, a, 8'h00);
      ok = 1'b0;
      repeat (3)
      begin
         @(posedge clk_i);
         if (!ok) d = rdata_i;
         ok |= (rvalid_i === 1'b1);
      end
   endtask : rd
   // all four bytes inside one write transaction
   task automatic wr4(input logic [31:0] v);
      @(posedge clk_i) txn_o <= 1'b1;
      for (int i = 0; i < 4; i++) op(1'b1, 8'h1b + 8'(i), v[8*i+:8]);
      txn_o <= 1'b0;
   endtask : wr4
   task automatic snap;
      @(posedge clk_i) rd_start_o <= 1'b1;
      @(posedge clk_i) rd_start_o <= 1'b0;
   endtask : snap
endmodule : tsec_host_model

// file: verif/tsec_top_bench.sv
// self-checking bench for the stamp and epoch block
// assumes the host model stands in for the i2c slave
`timescale 1ns/1ps
module tsec_top_bench;
   logic clk, srst, en, ow, clr, ev, tick, wp, ok, txn, rs, rv, ce, sv;
   tsec_pkg::tsec_cal_t cal;
   tsec_pkg::tsec_bus_req_t req;
   logic [7:0] rdata, d;
   logic [31:0] cnt;
   int error_cnt = 0;
   int comparisons = 0;
   tsec_top u_tsec_top (.sys_clk_i(clk), .srst_i(srst), .ce_i(ce), .bus_req_i(req),
      .bus_wr_txn_i(txn), .bus_rd_start_i(rs), .bus_rdata_o(rdata), .bus_rvalid_o(rv),
      .stamp_enable_i(en), .stamp_overwrite_select_i(ow), .stamp_clear_i(clr),
      .stamp_event_i(ev), .stamp_cal_i(cal), .tick_1hz_i(tick), .write_protect_i(wp),
      .epoch_count_o(cnt), .stamp_valid_o(sv));
   tsec_host_model u_tsec_host_model (.clk_i(clk), .rdata_i(rdata), .rvalid_i(rv),
      .req_o(req), .txn_o(txn), .rd_start_o(rs));
   task automatic end_of_test;
      if (error_cnt == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic rdb(input logic [7:0] a, input logic [7:0] exp);
      u_tsec_host_model.rd(a, d, ok);
      if (!ok)
      begin
         error_cnt++;
         end_of_test();
      end
      else
         chk({24'h0, d}, {24'h0, exp});
   endtask : rdb
   // one-cycle pulse on event, clear, tick
   task automatic pulse(input logic [2:0] p);
      @(posedge clk) {ev, clr, tick} <= p;
      @(posedge clk) {ev, clr, tick} <= 3'b000;
      #1;
   endtask : pulse
   task automatic stamps;
      @(posedge clk) en <= 1'b1;
      cal <= '{month: 5'h12, year: 8'h99};
      pulse(3'b100);
      chk({31'h0, sv}, 32'h1);
      @(posedge clk) cal <= '{month: 5'h05, year: 8'h23};
      pulse(3'b100);
      rdb(8'h19, 8'h12);
      rdb(8'h1a, 8'h99);
      u_tsec_host_model.op(1'b1, 8'h19, 8'hff);
      u_tsec_host_model.op(1'b1, 8'h1a, 8'h00);
      rdb(8'h19, 8'h12);
      rdb(8'h1a, 8'h99);
      @(posedge clk) ow <= 1'b1;
      pulse(3'b100);
      rdb(8'h19, 8'h05);
      rdb(8'h1a, 8'h23);
      pulse(3'b010);
      chk({31'h0, sv}, 32'h0);
      rdb(8'h19, 8'h00);
      rdb(8'h1a, 8'h00);
      @(posedge clk) en <= 1'b0;
      pulse(3'b100);
      rdb(8'h19, 8'h00);
      @(posedge clk) en <= 1'b1;
      pulse(3'b100);
      rdb(8'h19, 8'h05);
   endtask : stamps
   task automatic epoch;
      fork
         u_tsec_host_model.wr4(32'hffff_fffe);
         begin
            repeat (4) @(posedge clk);
            pulse(3'b001);
         end
      join
      #1 chk(cnt, 32'hffff_fffe);
      pulse(3'b001);
      chk(cnt, 32'hffff_ffff);
      pulse(3'b001);
      chk(cnt, 32'h0);
      u_tsec_host_model.wr4(32'h1234_5678);
      #1 chk(cnt, 32'h1234_5678);
      u_tsec_host_model.snap();
      pulse(3'b001);
      rdb(8'h1b, 8'h78);
      rdb(8'h1c, 8'h56);
      rdb(8'h1d, 8'h34);
      rdb(8'h1e, 8'h12);
      rdb(8'h40, 8'h00);
      @(posedge clk) wp <= 1'b1;
      u_tsec_host_model.op(1'b1, 8'h1b, 8'h00);
      #1 chk(cnt, 32'h1234_5679);
      @(posedge clk) ce <= 1'b0;
      pulse(3'b001);
      chk(cnt, 32'h1234_5679);
      @(posedge clk) ce <= 1'b1;
      pulse(3'b001);
      chk(cnt, 32'h1234_567a);
   endtask : epoch
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial
   begin
      {srst, en, ow, clr, ev, tick, wp} = 7'b1000000;
      ce = 1'b1;
      cal = '0;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      #1 chk(cnt, 32'h0);
      rdb(8'h19, 8'h00);
      rdb(8'h1a, 8'h00);
      stamps();
      epoch();
      end_of_test();
   end
endmodule : tsec_top_bench
